// ### aoi_defines.svh
`ifndef AOI_DEFINES_SVH
`define AOI_DEFINES_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define AOI_REG_PERF_ONE        8'h03
`define AOI_REG_PERF_TWO        8'h4a
`define AOI_REG_SWING           8'h01
`define AOI_REG_STRENGTH        8'h26
`define AOI_REG_FORMAT          8'h3d
`define AOI_REG_IFACE           8'h41
`define AOI_REG_PWR             8'h43

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define AOI_SWING_LSB           2
`define AOI_SWING_MSB           7
`define AOI_STR_DATA_BIT        0
`define AOI_STR_CLK_BIT         1
`define AOI_FORMAT_BIT          7
`define AOI_IFACE_BIT           7
`define AOI_OBUF_PDN_BIT        4

// ------------------------------------------------------------
// Reset values and codes
// ------------------------------------------------------------
`define AOI_REG_RESET           8'h00
`define AOI_POS_CLIP_OB         12'hfff
`define AOI_POS_CLIP_TC         12'h7ff
`define AOI_NEG_CLIP_OB         12'h000
`define AOI_NEG_CLIP_TC         12'h800
`define AOI_MSB_FLIP            12'h800

`endif

// ### aoi_pkg.sv
package aoi_pkg;

    typedef enum logic [1:0] {
        AOI_TC_DDR  = 2'b00,
        AOI_TC_PAR  = 2'b01,
        AOI_OB_PAR  = 2'b11,
        AOI_OB_DDR  = 2'b10
    } aoi_strap_type;

    typedef enum logic [1:0] {
        AOI_SRC_PIN = 2'b00,
        AOI_SRC_REG = 2'b01
    } aoi_cfg_src_type;

endpackage : aoi_pkg

// ### aoi_stream_if.sv
`timescale 1ns/1ps
`default_nettype none
interface aoi_stream_if #(parameter int W = 14) ();
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : aoi_stream_if
`default_nettype wire

// ### aoi_skid_buf.sv
`timescale 1ns/1ps
`default_nettype none
module aoi_skid_buf #(
    parameter int W = 14
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Streams
    aoi_stream_if.snk in_s,
    aoi_stream_if.src out_s
);
    logic [W-1:0] mem_ff [2];
    logic         wp_ff;
    logic         rp_ff;
    logic [1:0]   cnt_ff;
    logic         push;
    logic         pop;

    assign in_s.ready  = (cnt_ff != 2'd2);
    assign out_s.valid = (cnt_ff != 2'd0);
    assign out_s.data  = mem_ff[rp_ff];
    assign push        = in_s.valid && in_s.ready;
    assign pop         = out_s.valid && out_s.ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wp_ff] <= in_s.data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wp_ff  <= 1'b0;
            rp_ff  <= 1'b0;
            cnt_ff <= 2'd0;
        end else begin
            if (push) begin
                wp_ff <= ~wp_ff;
            end
            if (pop) begin
                rp_ff <= ~rp_ff;
            end
            cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule : aoi_skid_buf
`default_nettype wire

// ### aoi_strap_sync.sv
`timescale 1ns/1ps
`default_nettype none
module aoi_strap_sync #(
    parameter int W = 5
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Levels
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;

    // Change accepted once second and third stage agree
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_ff    <= '0;
            s2_ff    <= '0;
            s3_ff    <= '0;
            sync_out <= '0;
        end else begin
            s1_ff <= async_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            for (int i = 0; i < W; i++) begin
                if (s2_ff[i] == s3_ff[i]) begin
                    sync_out[i] <= s3_ff[i];
                end
            end
        end
    end
endmodule : aoi_strap_sync
`default_nettype wire

// ### aoi_out_iface.sv
// How it works
// - Four strap levels pick format and interface
// - Enable pin low disables output buffers
// - Serial data pin becomes standby strap
// - Performance modes settable by register only
// - Twelve-bit sample with synchronous output clock
// - Register bit or strap picks interface
// - DDR carries two bits per pair
// - Even bits on fall, odd on rise
// - Swing field sets differential output level
// - Double-strength setting for halved termination
// - Separate strength bits for data, clock
// - Parallel mode: one pin per bit
// - Over-range high when input beyond full scale
// - Over-range held while overload persists
// - Over-range single-ended, any interface
// - Positive clip FFFh or 7FFh
// - Negative clip 000h or 800h
// - Disabled buffers float data pins and output_clock, not diff_output_clock_pos
`timescale 1ns/1ps
`default_nettype none
`include "aoi_defines.svh"
module aoi_out_iface #(
    parameter int N_BITS = 12,
    parameter int N_PAIR = 6
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // Sample stream from converter core
    input  wire logic              smp_valid,
    output logic                   smp_ready,
    input  wire logic [N_BITS-1:0] smp_code,
    input  wire logic              smp_over_pos,
    input  wire logic              smp_over_neg,
    // Strap pins (decoded comparator levels, format strap as 2-bit level)
    input  wire logic [1:0]        format_strap_pin,
    input  wire logic              output_enable_pin,
    input  wire logic              serial_data_in_pin,
    input  wire logic              reset_pin,
    // Register write port from serial interface
    input  wire logic              reg_wr,
    input  wire logic [7:0]        reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_sw_reset,
    output logic      [7:0]        reg_rdata,
    input  wire logic              receiver_ready,
    // Parallel outputs (oe low means driven)
    output logic      [N_BITS-1:0] output_data,
    output logic      [N_BITS-1:0] output_data_oe_n,
    output logic                   output_clock,
    output logic                   output_clock_oe_n,
    // DDR outputs: pair value per half period
    output logic      [N_PAIR-1:0] ddr_pair,
    output logic      [N_PAIR-1:0] ddr_pair_oe_n,
    output logic                   diff_output_clock_pos,
    // Over-range and mode status
    output logic                   overrange_flag,
    output logic                   standby,
    output logic                   ddr_mode,
    output logic                   offset_binary,
    output logic      [5:0]        swing_code,
    output logic                   data_double_drive_bit,
    output logic                   clock_double_drive_bit,
    output logic                   perf_mode_one,
    output logic                   perf_mode_two
);
    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    logic [4:0] pins_s;

    aoi_strap_sync #(.W(5)) u_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in ({format_strap_pin, output_enable_pin, serial_data_in_pin, reset_pin}),
        .sync_out (pins_s)
    );

    aoi_pkg::aoi_strap_type strap;
    logic                   oe_pin_s;
    logic                   serial_data_in_pin_s;
    logic                   pin_mode;

    assign strap    = aoi_pkg::aoi_strap_type'(pins_s[4:3]);
    assign oe_pin_s = pins_s[2];
    assign serial_data_in_pin_s  = pins_s[1];
    // Reset pin tied high means no serial interface in use
    assign pin_mode = pins_s[0];

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    logic [7:0] perf_mode_one_ctrl_ff;
    logic [7:0] perf_mode_two_ctrl_ff;
    logic [7:0] swing_ff;
    logic [7:0] strength_ff;
    logic [7:0] format_ff;
    logic [7:0] iface_ff;
    logic [7:0] pwr_ff;
    logic       reg_src_ff;
    logic       wr_ok;

    // Register writes only while the serial interface is in use
    assign wr_ok = reg_wr && !pin_mode;

    always_ff @(posedge clk) begin
        if (!rst_n || reg_sw_reset) begin
            perf_mode_one_ctrl_ff <= `AOI_REG_RESET;
            perf_mode_two_ctrl_ff <= `AOI_REG_RESET;
            swing_ff              <= `AOI_REG_RESET;
            strength_ff           <= `AOI_REG_RESET;
            format_ff             <= `AOI_REG_RESET;
            iface_ff              <= `AOI_REG_RESET;
            pwr_ff                <= `AOI_REG_RESET;
            reg_src_ff            <= 1'b0;
        end else if (wr_ok) begin
            if (reg_addr == `AOI_REG_PERF_ONE) begin
                perf_mode_one_ctrl_ff <= reg_wdata;
            end else if (reg_addr == `AOI_REG_PERF_TWO) begin
                perf_mode_two_ctrl_ff <= reg_wdata;
            end else if (reg_addr == `AOI_REG_SWING) begin
                swing_ff <= reg_wdata;
            end else if (reg_addr == `AOI_REG_STRENGTH) begin
                strength_ff <= reg_wdata;
            end else if (reg_addr == `AOI_REG_FORMAT) begin
                format_ff  <= reg_wdata;
                reg_src_ff <= 1'b1;
            end else if (reg_addr == `AOI_REG_IFACE) begin
                iface_ff   <= reg_wdata;
                reg_src_ff <= 1'b1;
            end else if (reg_addr == `AOI_REG_PWR) begin
                pwr_ff <= reg_wdata;
            end
        end
    end

    always_comb begin
        if (reg_addr == `AOI_REG_PERF_ONE) begin
            reg_rdata = perf_mode_one_ctrl_ff;
        end else if (reg_addr == `AOI_REG_PERF_TWO) begin
            reg_rdata = perf_mode_two_ctrl_ff;
        end else if (reg_addr == `AOI_REG_SWING) begin
            reg_rdata = swing_ff;
        end else if (reg_addr == `AOI_REG_STRENGTH) begin
            reg_rdata = strength_ff;
        end else if (reg_addr == `AOI_REG_FORMAT) begin
            reg_rdata = format_ff;
        end else if (reg_addr == `AOI_REG_IFACE) begin
            reg_rdata = iface_ff;
        end else if (reg_addr == `AOI_REG_PWR) begin
            reg_rdata = pwr_ff;
        end else begin
            reg_rdata = 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Mode selection
    // ------------------------------------------------------------
    logic ddr_sel;
    logic ob_sel;
    logic buf_on;

    // Strap rules until software writes a format or interface register
    always_comb begin
        if (reg_src_ff && !pin_mode) begin
            ddr_sel = !iface_ff[`AOI_IFACE_BIT];
            ob_sel  = format_ff[`AOI_FORMAT_BIT];
        end else begin
            ddr_sel = (strap == aoi_pkg::AOI_TC_DDR) || (strap == aoi_pkg::AOI_OB_DDR);
            ob_sel  = (strap == aoi_pkg::AOI_OB_PAR) || (strap == aoi_pkg::AOI_OB_DDR);
        end
    end

    assign buf_on = oe_pin_s && !pwr_ff[`AOI_OBUF_PDN_BIT];

    // ------------------------------------------------------------
    // Sample formatting and clipping
    // ------------------------------------------------------------
    aoi_stream_if #(.W(N_BITS + 1)) fmt_s ();
    aoi_stream_if #(.W(N_BITS + 1)) buf_s ();

    logic [N_BITS-1:0] fmt_code;

    always_comb begin
        if (smp_over_pos) begin
            fmt_code = ob_sel ? `AOI_POS_CLIP_OB : `AOI_POS_CLIP_TC;
        end else if (smp_over_neg) begin
            fmt_code = ob_sel ? `AOI_NEG_CLIP_OB : `AOI_NEG_CLIP_TC;
        end else begin
            // Core code is twos complement; offset binary flips the sign bit
            fmt_code = ob_sel ? (smp_code ^ `AOI_MSB_FLIP) : smp_code;
        end
    end

    assign fmt_s.valid = smp_valid;
    assign fmt_s.data  = {smp_over_pos | smp_over_neg, fmt_code};
    assign smp_ready   = fmt_s.ready;

    // Two entries absorb one stalled sample without loss
    aoi_skid_buf #(.W(N_BITS + 1)) u_buf (
        .clk   (clk),
        .rst_n (rst_n),
        .in_s  (fmt_s),
        .out_s (buf_s)
    );

    // ------------------------------------------------------------
    // Output phase: one sample per two clk cycles
    // ------------------------------------------------------------
    logic              phase_ff;
    logic [N_BITS-1:0] word_ff;
    logic              ovr_ff;

    // Phase 0 is the low half of the output clock, phase 1 the high half
    assign buf_s.ready = phase_ff && receiver_ready;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            phase_ff <= 1'b0;
        end else begin
            phase_ff <= ~phase_ff;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            word_ff <= '0;
            ovr_ff  <= 1'b0;
        end else if (buf_s.valid && buf_s.ready) begin
            word_ff <= buf_s.data[N_BITS-1:0];
            // Level follows each sample, so it holds during overload
            ovr_ff  <= buf_s.data[N_BITS];
        end
    end

    // ------------------------------------------------------------
    // Pins
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            output_clock          <= 1'b0;
            diff_output_clock_pos <= 1'b0;
        end else begin
            // Data changes while clock low, so rising edge sees it stable
            output_clock          <= phase_ff;
            diff_output_clock_pos <= phase_ff;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            output_data    <= '0;
            overrange_flag <= 1'b0;
        end else begin
            output_data    <= word_ff;
            // Same stage as the data pins so flag and clip code line up
            overrange_flag <= ovr_ff;
        end
    end

    // Pair i carries bit 2i after the fall and bit 2i+1 after the rise
    genvar gi;
    generate
        for (gi = 0; gi < N_PAIR; gi++) begin : g_pair
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    ddr_pair[gi] <= 1'b0;
                end else begin
                    ddr_pair[gi] <= phase_ff ? word_ff[2*gi+1] : word_ff[2*gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            output_data_oe_n  <= '1;
            ddr_pair_oe_n     <= '1;
            output_clock_oe_n <= 1'b1;
        end else begin
            output_data_oe_n  <= {N_BITS{!(buf_on && !ddr_sel)}};
            ddr_pair_oe_n     <= {N_PAIR{!(buf_on && ddr_sel)}};
            output_clock_oe_n <= !buf_on;
        end
    end

    // ------------------------------------------------------------
    // Mode status outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            standby                <= 1'b0;
            ddr_mode               <= 1'b0;
            offset_binary          <= 1'b0;
            swing_code             <= '0;
            data_double_drive_bit  <= 1'b0;
            clock_double_drive_bit <= 1'b0;
            perf_mode_one          <= 1'b0;
            perf_mode_two          <= 1'b0;
        end else begin
            standby                <= pin_mode && serial_data_in_pin_s;
            ddr_mode               <= ddr_sel;
            offset_binary          <= ob_sel;
            swing_code             <= swing_ff[`AOI_SWING_MSB:`AOI_SWING_LSB];
            data_double_drive_bit  <= strength_ff[`AOI_STR_DATA_BIT];
            clock_double_drive_bit <= strength_ff[`AOI_STR_CLK_BIT];
            perf_mode_one          <= perf_mode_one_ctrl_ff == 8'h03;
            perf_mode_two          <= perf_mode_two_ctrl_ff[0];
        end
    end
endmodule : aoi_out_iface
`default_nettype wire

// ### aoi_out_iface_chk.sv
`timescale 1ns/1ps
`default_nettype none
module aoi_chk #(
    parameter int N_BITS = 12,
    parameter int N_PAIR = 6
) (
    // Clock and reset
    input wire logic              clk,
    input wire logic              rst_n,
    // Pins and register port
    input wire logic [1:0]        format_strap_pin,
    input wire logic              output_enable_pin,
    input wire logic              serial_data_in_pin,
    input wire logic              reset_pin,
    input wire logic              reg_wr,
    input wire logic [7:0]        reg_addr,
    input wire logic [7:0]        reg_wdata,
    input wire logic              reg_sw_reset,
    input wire logic              smp_ready,
    // Outputs
    input wire logic [N_BITS-1:0] output_data,
    input wire logic [N_BITS-1:0] output_data_oe_n,
    input wire logic              output_clock,
    input wire logic              output_clock_oe_n,
    input wire logic [N_PAIR-1:0] ddr_pair_oe_n,
    input wire logic              diff_output_clock_pos,
    input wire logic              overrange_flag,
    input wire logic              standby,
    input wire logic              ddr_mode,
    input wire logic              offset_binary,
    input wire logic              perf_mode_one,
    input wire logic              perf_mode_two
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Straps stop ruling once the format or interface register is written
    logic src_reg_ff;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            src_reg_ff <= 1'b0;
        end else if (reg_wr && !reset_pin && (reg_addr == 8'h3d || reg_addr == 8'h41)) begin
            src_reg_ff <= 1'b1;
        end
    end

    strap_mode_a: assert property (!src_reg_ff && $stable(format_strap_pin)[*7] |->
        ddr_mode == !format_strap_pin[0] && offset_binary == format_strap_pin[1]) else $error("strap mode wrong");
    oe_off_a: assert property (!output_enable_pin[*8] |->
        &output_data_oe_n && &ddr_pair_oe_n && output_clock_oe_n) else $error("buffers driven while disabled");
    ddr_sel_a: assert property (ddr_mode && $past(ddr_mode) |-> &output_data_oe_n)
        else $error("parallel pins driven in ddr");
    par_sel_a: assert property (!ddr_mode && !$past(ddr_mode) |-> &ddr_pair_oe_n)
        else $error("pairs driven in parallel");
    clip_code_a: assert property (overrange_flag && !output_data_oe_n[0] && $stable(offset_binary) |->
        (offset_binary ? (output_data == 12'hfff || output_data == 12'h000)
                       : (output_data == 12'h7ff || output_data == 12'h800))) else $error("bad clip code");
    clk_toggle_a: assert property ($past(rst_n, 2) |-> output_clock != $past(output_clock))
        else $error("output clock stalled");
    diff_clk_a: assert property (diff_output_clock_pos == output_clock)
        else $error("clock copies differ");
    standby_pin_a: assert property ((reset_pin && serial_data_in_pin)[*7] |-> standby)
        else $error("standby strap ignored");
    run_pin_a: assert property ((reset_pin && !serial_data_in_pin)[*7] |-> !standby)
        else $error("standby without strap");
    perf_lock_a: assert property (reset_pin[*6] |-> !$rose(perf_mode_one) && !$rose(perf_mode_two))
        else $error("perf mode set in pin mode");
    perf_one_a: assert property (!reset_pin[*6] ##0 (reg_wr && !reg_sw_reset && reg_addr == 8'h03) |->
        ##2 perf_mode_one == ($past(reg_wdata, 2) == 8'h03)) else $error("perf mode one wrong");
    perf_two_a: assert property (!reset_pin[*6] ##0 (reg_wr && !reg_sw_reset && reg_addr == 8'h4a) |->
        ##2 perf_mode_two == $past(reg_wdata[0], 2)) else $error("perf mode two wrong");

    cover property (!smp_ready);
    cover property (overrange_flag && !output_data_oe_n[0]);
    cover property (perf_mode_one && perf_mode_two);
    cover property (standby);
endmodule : aoi_chk

bind aoi_out_iface aoi_chk #(.N_BITS(N_BITS), .N_PAIR(N_PAIR)) aoi_chk_i (.*);
`default_nettype wire

// ### aoi_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
module aoi_rx_model (
    // Clock and stall control
    input  wire logic        clk,
    input  wire logic        stall_en,
    output logic             receiver_ready,
    // Device outputs
    input  wire logic [11:0] output_data,
    input  wire logic [11:0] output_data_oe_n,
    input  wire logic        output_clock,
    input  wire logic [5:0]  ddr_pair,
    input  wire logic [5:0]  ddr_pair_oe_n,
    input  wire logic        overrange_flag
);
    logic [12:0] q[$];
    logic [12:0] last     = 13'h0;
    logic [12:0] cur      = 13'h0;
    logic [11:0] ddr_word = 12'h0;
    logic        got;
    initial receiver_ready = 1'b1;
    // Mid-cycle sampling; a held word is pushed once only
    always @(negedge clk) begin
        receiver_ready <= !stall_en || ($urandom_range(3) != 0);
        got = 1'b0;
        if (!ddr_pair_oe_n[0]) begin
            for (int i = 0; i < 6; i++) ddr_word[2*i+output_clock] = ddr_pair[i];
            got = output_clock;
            cur = {overrange_flag, ddr_word};
        end else if (!output_data_oe_n[0] && output_clock) begin
            got = 1'b1;
            cur = {overrange_flag, output_data};
        end
        if (got && cur[11:0] !== last[11:0]) q.push_back(cur);
        if (got) last = cur;
    end
endmodule : aoi_rx_model
`default_nettype wire

// ### testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 0, rst_n = 0, smp_valid = 0, smp_over_pos = 0, smp_over_neg = 0;
    logic output_enable_pin = 1, serial_data_in_pin = 0, reset_pin = 0;
    logic reg_wr = 0, reg_sw_reset = 0, stall_en = 0;
    logic [11:0] smp_code = 0;
    logic [1:0]  format_strap_pin = 0;
    logic [7:0]  reg_addr = 0, reg_wdata = 0, reg_rdata;
    logic smp_ready, output_clock, output_clock_oe_n, diff_output_clock_pos, overrange_flag, standby;
    logic ddr_mode, offset_binary, data_double_drive_bit, clock_double_drive_bit;
    logic perf_mode_one, perf_mode_two, receiver_ready;
    logic [11:0] output_data, output_data_oe_n;
    logic [5:0]  ddr_pair, ddr_pair_oe_n, swing_code;
    int err_total = 0, samples_checked = 0, cyc = 0;

    aoi_out_iface aoi_out_iface_i (.*);
    aoi_rx_model aoi_rx_model_i (.*);

    always #2 clk = ~clk;

    // --------
    // Checking
    // --------
    task automatic chk(string n, logic [12:0] got, logic [12:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, exp, got);
        end
    endtask : chk

    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results

    function automatic logic [12:0] exp_w(logic [11:0] c, logic p, logic n, logic ob);
        if (p) return {1'b1, ob ? 12'hfff : 12'h7ff};
        if (n) return {1'b1, ob ? 12'h000 : 12'h800};
        return {1'b0, ob ? c ^ 12'h800 : c};
    endfunction : exp_w

    // --------
    // Drivers
    // --------
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge clk);
        reg_wr = 1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 0;
        repeat (2) @(negedge clk);
    endtask : wr

    task automatic rchk(logic [7:0] a, logic [7:0] e);
        @(negedge clk);
        reg_addr = a;
        #1;
        chk("rdata", reg_rdata, e);
    endtask : rchk

    // Sends n samples at full rate; the partner stalls at random while stall_en is set
    task automatic stream(int n, logic ob, logic ddr);
        logic [12:0] e, prev;
        logic [11:0] c;
        logic [2:0]  pick;
        logic [12:0] exq[$];
        int t;
        aoi_rx_model_i.q.delete();
        prev = aoi_rx_model_i.last;
        for (int k = 0; k < n; k++) begin
            pick = (k < 4) ? 3'(k) : (k == n - 1) ? 3'd7 : 3'($urandom_range(7));
            c = (k == 2) ? 12'h7ff : (k == 3) ? 12'h800 : 12'($urandom);
            e = exp_w(c, pick == 0, pick == 1, ob);
            if (e[11:0] == prev[11:0]) begin
                c = c + 12'h1;
                pick = 3'd7;
                e = exp_w(c, 1'b0, 1'b0, ob);
            end
            smp_valid = 1;
            smp_code = c;
            smp_over_pos = (pick == 0);
            smp_over_neg = (pick == 1);
            t = 0;
            while (!smp_ready && t < 200) begin
                @(negedge clk);
                t++;
            end
            @(negedge clk);
            exq.push_back(e);
            prev = e;
        end
        smp_valid = 0;
        t = 0;
        while (aoi_rx_model_i.q.size() < n && t < 400) begin
            @(negedge clk);
            t++;
        end
        chk("count", 13'(aoi_rx_model_i.q.size()), 13'(n));
        for (int i = 0; i < n && i < aoi_rx_model_i.q.size(); i++) begin
            if (ddr) chk("ddr word", {1'b0, aoi_rx_model_i.q[i][11:0]}, {1'b0, exq[i][11:0]});
            else chk("par word", aoi_rx_model_i.q[i], exq[i]);
        end
    endtask : stream

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            results();
        end
    end

    // --------
    // Sequence
    // --------
    initial begin
        void'($urandom(32'h6fb9));
        repeat (2) @(negedge clk);
        rst_n = 1;
        repeat (8) @(negedge clk);
        chk("perf one", perf_mode_one, 0);
        rchk(8'h03, 8'h00);
        wr(8'h03, 8'h03);
        wr(8'h4a, 8'h01);
        wr(8'h01, 8'hfc);
        wr(8'h26, 8'h03);
        chk("perf one", perf_mode_one, 1);
        chk("perf two", perf_mode_two, 1);
        chk("swing", swing_code, 6'h3f);
        chk("data drive", data_double_drive_bit, 1);
        rchk(8'h4a, 8'h01);
        rchk(8'h22, 8'h00);
        wr(8'h26, 8'h02);
        chk("data drive", data_double_drive_bit, 0);
        chk("clock drive", clock_double_drive_bit, 1);
        wr(8'h03, 8'h01);
        chk("perf one", perf_mode_one, 0);
        $display("test registers done");
        reset_pin = 1;
        serial_data_in_pin = 1;
        repeat (8) @(negedge clk);
        chk("standby", standby, 1);
        wr(8'h4a, 8'h00);
        chk("perf two", perf_mode_two, 1);
        serial_data_in_pin = 0;
        repeat (8) @(negedge clk);
        chk("standby", standby, 0);
        reset_pin = 0;
        repeat (8) @(negedge clk);
        reg_sw_reset = 1;
        @(negedge clk);
        reg_sw_reset = 0;
        rchk(8'h4a, 8'h00);
        $display("test pin mode done");
        for (int m = 0; m < 4; m++) begin
            format_strap_pin = 2'(m);
            stall_en = m[0];
            repeat (12) @(negedge clk);
            chk("ddr mode", ddr_mode, !format_strap_pin[0]);
            chk("offset bin", offset_binary, format_strap_pin[1]);
            stream(40, format_strap_pin[1], !format_strap_pin[0]);
            $display("test strap %0d done", m);
        end
        output_enable_pin = 0;
        repeat (10) @(negedge clk);
        chk("data oe", output_data_oe_n, 12'hfff);
        chk("clock oe", output_clock_oe_n, 1);
        output_enable_pin = 1;
        wr(8'h43, 8'h10);
        repeat (4) @(negedge clk);
        chk("data oe", output_data_oe_n, 12'hfff);
        wr(8'h43, 8'h00);
        format_strap_pin = 2'b00;
        wr(8'h41, 8'h80);
        repeat (4) @(negedge clk);
        chk("ddr mode", ddr_mode, 0);
        $display("test buffers done");
        results();
    end
endmodule : testbench
`default_nettype wire
